// file: dv/ams_chk.sv
// Purpose: Port checks for ams_top
// Assumes: Ports only, one clock
// Notes: Bound below
`timescale 1ns/1ps
module ams_chk (
  input logic MCLK, // Clock
  input logic RST_N, // Reset
  input logic EXEC, // Valid
  input logic [4:0] CLASS3_SUBOP, // Code
  input logic SRC_SEL, // Source
  input logic DST_SEL, // Dest
  input logic [15:0] ACC_IN, // Acc
  input logic [15:0] ACC_OFS_IN, // Partner
  input logic [15:0] ACC_WDATA, // Result
  input logic ACC_WE, // Strobe
  input logic ACC_WSEL, // Target
  input logic [3:0] SHIFT_VALUE_REG, // Shift
  input logic [15:0] PRODUCT_HIGH_REG, // High
  input logic [15:0] MULTIPLIER_OPERAND_REG, // Mult
  input logic UNSIGNED_MULTIPLY_FLAG // Mode
);
  wire [4:0] op = EXEC ? CLASS3_SUBOP : 5'h00;
  wire [15:0] src = SRC_SEL ? ACC_OFS_IN : ACC_IN;
  wire [3:0] src_lo = src[3:0];
  wire [15:0] prod_lo = MULTIPLIER_OPERAND_REG * src;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_refused_quiet: assert property (op < 5'h14 |=> !ACC_WE && $stable(PRODUCT_HIGH_REG))
    else $error("refused code acted");
  a_write_strobe: assert property (op inside {[5'h18:5'h1D]} |=> ACC_WE && ACC_WSEL == $past(DST_SEL))
    else $error("missing write");
  a_no_acc_write: assert property (op inside {[5'h14:5'h17], 5'h1E, 5'h1F} |=> !ACC_WE)
    else $error("stray write");
  a_sv_load: assert property (op == 5'h14 |=> SHIFT_VALUE_REG == $past(src_lo))
    else $error("shift value load");
  a_ph_load: assert property (op == 5'h15 |=> PRODUCT_HIGH_REG == $past(src))
    else $error("high load");
  a_mr_signed: assert property (op == 5'h16 |=> !UNSIGNED_MULTIPLY_FLAG && MULTIPLIER_OPERAND_REG == $past(src))
    else $error("signed load");
  a_mr_unsigned: assert property (op == 5'h17 |=> UNSIGNED_MULTIPLY_FLAG && MULTIPLIER_OPERAND_REG == $past(src))
    else $error("unsigned load");
  a_mul_low: assert property (op == 5'h1B |=> ACC_WDATA == $past(prod_lo))
    else $error("product low");
endmodule // ams_chk

bind ams_top ams_chk u_chk (.MCLK(MCLK), .RST_N(RST_N), .EXEC(EXEC), .CLASS3_SUBOP(CLASS3_SUBOP),
  .SRC_SEL(SRC_SEL), .DST_SEL(DST_SEL), .ACC_IN(ACC_IN), .ACC_OFS_IN(ACC_OFS_IN),
  .ACC_WDATA(ACC_WDATA), .ACC_WE(ACC_WE), .ACC_WSEL(ACC_WSEL), .SHIFT_VALUE_REG(SHIFT_VALUE_REG),
  .PRODUCT_HIGH_REG(PRODUCT_HIGH_REG), .MULTIPLIER_OPERAND_REG(MULTIPLIER_OPERAND_REG),
  .UNSIGNED_MULTIPLY_FLAG(UNSIGNED_MULTIPLY_FLAG));

// file: dv/tb.sv
// Purpose: Self-checking bench for ams_top
// Assumes: Model tracks all four flags; string chaining varies per test
// Notes: Driver queues notes, monitor compares
`timescale 1ns/1ps
module tb;
  typedef struct {logic [4:0] c; logic we, ws, um; logic [15:0] wd, ph, mr; logic [3:0] sv;
    logic [1:0] zs; logic [3:0] fl;} ams_note_t;
  ams_note_t q[$];
  ams_note_t n;
  logic mclk = 0, rst_n = 0, exec = 0, ssel = 0, dsel = 0, ext = 0, due = 0, m_um = 0;
  logic [4:0] op = 0;
  logic [15:0] acc = 0, ofs = 0, m_ph = 0, m_mr = 0;
  logic [3:0] m_sv = 0;
  logic smode = 0, m_str = 0;
  logic [3:0] m_fl = 0;
  logic [4:0] sh[4] = '{5'h1A, 5'h1C, 5'h1D, 5'h1F};
  logic [4:0] mu[4] = '{5'h18, 5'h19, 5'h1B, 5'h1E};
  int err_count = 0, comparisons = 0;
  wire [15:0] wd, ph, mr;
  wire [3:0] sv;
  wire we, ws, um, zf, sf, cf, vf;
  ams_top uut (.MCLK(mclk), .RST_N(rst_n), .EXEC(exec), .CLASS3_SUBOP(op), .SRC_SEL(ssel),
    .DST_SEL(dsel), .STRING_MODE(smode), .EXTEND_SIGN_FLAG(ext), .ACC_IN(acc), .ACC_OFS_IN(ofs),
    .ACC_WDATA(wd), .ACC_WE(we), .ACC_WSEL(ws), .SHIFT_VALUE_REG(sv), .PRODUCT_HIGH_REG(ph),
    .MULTIPLIER_OPERAND_REG(mr), .UNSIGNED_MULTIPLY_FLAG(um), .ZERO_FLAG(zf), .CARRY_FLAG(cf),
    .SIGN_FLAG(sf), .OVF_FLAG(vf));
  initial forever #10 mclk = ~mclk;

  task automatic chk(input string nm, input logic [20:0] e, s);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic issue(input logic [4:0] c, input logic [15:0] a, b, input logic s, d, x);
    logic [15:0] src, prt, r;
    logic [31:0] v;
    logic [16:0] u, t;
    logic sb;
    @(posedge mclk);
    exec <= 1'b1;
    op <= c;
    acc <= a;
    ofs <= b;
    ssel <= s;
    dsel <= d;
    ext <= x;
    smode <= m_str;
    src = s ? b : a;
    prt = s ? a : b;
    if (c inside {5'h1A, 5'h1C, 5'h1D, 5'h1F})
      v = {{16{x & src[15]}}, src} << m_sv;
    else
      v = {{16{~m_um & m_mr[15]}}, m_mr} * {{16{~m_um & src[15]}}, src};
    sb = c inside {5'h18, 5'h1C};
    // Unsigned view gives carry, sign-extended view gives overflow
    u = sb ? {1'b0, prt} - {1'b0, v[15:0]} - 17'(m_str & ~m_fl[2])
      : {1'b0, prt} + {1'b0, v[15:0]} + 17'(m_str & m_fl[2]);
    t = sb ? {prt[15], prt} - {v[15], v[15:0]} - 17'(m_str & ~m_fl[2])
      : {prt[15], prt} + {v[15], v[15:0]} + 17'(m_str & m_fl[2]);
    r = c inside {5'h18, 5'h19, 5'h1C, 5'h1D} ? u[15:0] : v[15:0];
    if (c inside {[5'h14:5'h17]})
      m_fl = {src == 16'h0000, m_fl[2], src[15], m_fl[0]};
    else if (c inside {5'h18, 5'h19, 5'h1C, 5'h1D})
      m_fl = {r == 16'h0000 && !(m_str && !m_fl[3]), sb ^ u[16], r[15], t[16] ^ t[15]};
    else if (c inside {5'h1A, 5'h1B})
      m_fl = {r == 16'h0000, 1'b0, r[15], 1'b0};
    m_sv = (c == 5'h14) ? src[3:0] : m_sv;
    m_ph = (c == 5'h15) ? src : (c >= 5'h18) ? v[31:16] + (c == 5'h1E ? v[15] : 1'b0) : m_ph;
    m_mr = c inside {5'h16, 5'h17} ? src : m_mr;
    m_um = c inside {5'h16, 5'h17} ? c[0] : m_um;
    q.push_back('{c, c inside {[5'h18:5'h1D]}, d, m_um, r, m_ph, m_mr, m_sv,
      {src == 16'h0000, src[15]}, m_fl});
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Result lands one edge after the taking edge
  always @(negedge mclk)
  begin
    if (due)
    begin
      n = q.pop_front();
      chk("we wsel wdata", {n.we, n.we & n.ws, n.we ? n.wd : 16'h0000}, {we, we & ws, we ? wd : 16'h0000});
      chk("product high", n.ph, ph);
      chk("um mr sv", {n.um, n.mr, n.sv}, {um, mr, sv});
      if (n.c inside {[5'h14:5'h17]}) chk("zero sign", n.zs, {zf, sf});
      chk("flags zcso", n.fl, {zf, cf, sf, vf});
    end
    due = exec;
  end

  initial
  begin
    #200000;
    err_count++;
    close_out();
  end

  initial
  begin
    void'($urandom(40790));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) issue(5'(i), 16'($urandom), 16'($urandom), i[0], i[1], i[2]);
    $display("All codes done");
    for (int j = 0; j < 8; j++)
    begin
      m_str = j[2];
      issue(5'h14, 16'hFFFF, 16'h0000, 1'b0, 1'b0, 1'b0);
      issue(sh[j % 4], 16'h8001, 16'h7FFF, j[2], j[0], j[1]);
      issue(5'h16 | 5'(j[0]), 16'h8000, 16'h0001, 1'b0, 1'b0, 1'b0);
      issue(mu[j % 4], 16'hFFFF, 16'h8000, j[1], j[2], 1'b0);
    end
    $display("Boundary done");
    repeat (500)
    begin
      m_str = 1'($urandom);
      issue(5'h10 + 5'($urandom % 16), 16'($urandom), 16'($urandom), 1'($urandom),
        1'($urandom), 1'($urandom));
    end
    $display("Random done");
    @(posedge mclk);
    exec <= 1'b0;
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule // tb

// file: src/ams_defs.vh
// Purpose: Constants for the accumulator multiply/shift datapath
// Assumes: 16-bit accumulators, 5-bit class 3 sub-opcode
// Notes: Included by ams_top only, not by the multiplier or shifter
`ifndef AMS_DEFS_VH
`define AMS_DEFS_VH

`define AMS_OP_MOV_SV 5'h14
`define AMS_OP_MOV_PH 5'h15
`define AMS_OP_MOV_MR 5'h16
`define AMS_OP_LOAD_MULT_UNSIGNED_MR 5'h17
`define AMS_OP_MUL_SUB 5'h18
`define AMS_OP_MUL_ADD 5'h19
`define AMS_OP_SHL_XFR 5'h1A
`define AMS_OP_MUL_XFR 5'h1B
`define AMS_OP_SHL_SUB 5'h1C
`define AMS_OP_SHL_ADD 5'h1D
`define AMS_OP_MUL_HI 5'h1E
`define AMS_OP_SHL_HI 5'h1F

`define AMS_RST_WORD 16'h0000
`define AMS_RST_SV 4'h0
`define AMS_ROUND_BIT 15

`endif

// file: src/ams_mult.v
// Purpose: 16x16 multiplier, signed or unsigned
// Assumes: Operands from same clock domain
// Notes: Purely combinational
`timescale 1ns/1ps
module ams_mult #(
  parameter W = 16
) (
  input wire [W-1:0] a, // Multiplier operand
  input wire [W-1:0] b, // Accumulator operand
  input wire uns, // Unsigned mode
  output wire [2*W-1:0] p // Product
);
  wire signed [W:0] sa;
  wire signed [W:0] sb;
  wire signed [2*W+1:0] sp;
  assign sa = {~uns & a[W-1], a};
  assign sb = {~uns & b[W-1], b};
  assign sp = sa * sb;
  assign p = sp[2*W-1:0];
endmodule // ams_mult

// file: src/ams_shift.v
// Purpose: Left barrel shifter into double-width result
// Assumes: Count below W
// Notes: Upper half extended by sign when ext is set
`timescale 1ns/1ps
module ams_shift #(
  parameter W = 16,
  parameter CW = 4
) (
  input wire [W-1:0] a, // Value to shift
  input wire [CW-1:0] n, // Shift count
  input wire ext, // Sign extend
  output wire [2*W-1:0] r // Result
);
  wire [2*W-1:0] xa;
  assign xa = {{W{ext & a[W-1]}}, a};
  assign r = xa << n;
endmodule // ams_shift

// file: src/ams_top.v
// Purpose: Class 3 upper-group execution datapath
// Assumes: Accumulator file outside; one instruction per cycle
// Notes: Results for accumulators leave as a write strobe with data
`timescale 1ns/1ps
`include "ams_defs.vh"
module ams_top #(
  parameter W = 16,
  parameter CW = 4
) (
  input wire MCLK, // Core clock
  input wire RST_N, // Async reset, active low
  input wire EXEC, // Instruction valid this cycle
  input wire [4:0] CLASS3_SUBOP, // Sub-opcode
  input wire SRC_SEL, // Source select, 1 takes offset accumulator
  input wire DST_SEL, // Destination select, 1 writes offset accumulator
  input wire STRING_MODE, // String chaining active
  input wire EXTEND_SIGN_FLAG, // Sign extension mode
  input wire [W-1:0] ACC_IN, // Selected accumulator
  input wire [W-1:0] ACC_OFS_IN, // Offset partner accumulator
  output reg [W-1:0] ACC_WDATA, // Accumulator write data
  output reg ACC_WE, // Accumulator write strobe
  output reg ACC_WSEL, // Written accumulator, 1 offset
  output reg [CW-1:0] SHIFT_VALUE_REG, // Shift count
  output reg [W-1:0] PRODUCT_HIGH_REG, // Product high
  output reg [W-1:0] MULTIPLIER_OPERAND_REG, // Multiplier
  output reg UNSIGNED_MULTIPLY_FLAG, // Unsigned multiply mode
  output reg ZERO_FLAG, // Zero status
  output reg CARRY_FLAG, // Carry status
  output reg SIGN_FLAG, // Sign status
  output reg OVF_FLAG // Overflow status
);
  wire [W-1:0] src;
  wire [W-1:0] other;
  wire [2*W-1:0] prod;
  wire [2*W-1:0] shr;
  wire [W-1:0] prod_rnd_hi;
  reg [W-1:0] lo;
  reg [W:0] sum;
  reg do_sub;
  reg do_arith;
  reg do_xfer;
  reg wr_acc;
  reg alu_upd;
  reg [W-1:0] res;
  reg [W-1:0] ph_d;
  reg ph_we;
  reg ovf;
  reg z_new;

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  assign src = SRC_SEL ? ACC_OFS_IN : ACC_IN;
  assign other = SRC_SEL ? ACC_IN : ACC_OFS_IN;

  ams_mult #(
    .W(W)
  ) u_mult (
    .a(MULTIPLIER_OPERAND_REG),
    .b(src),
    .uns(UNSIGNED_MULTIPLY_FLAG),
    .p(prod)
  );

  ams_shift #(
    .W(W),
    .CW(CW)
  ) u_shift (
    .a(src),
    .n(SHIFT_VALUE_REG),
    .ext(EXTEND_SIGN_FLAG),
    .r(shr)
  );

  assign prod_rnd_hi = prod[2*W-1:W] + {{(W-1){1'b0}}, prod[`AMS_ROUND_BIT]};

  // ----------------------------------------
  // Decode and result
  // ----------------------------------------
  always @*
  begin
    lo = {W{1'b0}};
    do_sub = 1'b0;
    do_arith = 1'b0;
    do_xfer = 1'b0;
    wr_acc = 1'b0;
    alu_upd = 1'b0;
    ph_d = PRODUCT_HIGH_REG;
    ph_we = 1'b0;
    case (CLASS3_SUBOP)
      `AMS_OP_MOV_SV, `AMS_OP_MOV_MR, `AMS_OP_LOAD_MULT_UNSIGNED_MR:
      begin
        do_xfer = 1'b1;
      end
      `AMS_OP_MOV_PH:
      begin
        do_xfer = 1'b1;
        ph_d = src;
        ph_we = 1'b1;
      end
      `AMS_OP_MUL_SUB, `AMS_OP_MUL_ADD:
      begin
        lo = prod[W-1:0];
        do_arith = 1'b1;
        do_sub = (CLASS3_SUBOP == `AMS_OP_MUL_SUB);
        wr_acc = 1'b1;
        alu_upd = 1'b1;
        ph_d = prod[2*W-1:W];
        ph_we = 1'b1;
      end
      `AMS_OP_MUL_XFR:
      begin
        lo = prod[W-1:0];
        wr_acc = 1'b1;
        alu_upd = 1'b1;
        ph_d = prod[2*W-1:W];
        ph_we = 1'b1;
      end
      `AMS_OP_SHL_XFR:
      begin
        lo = shr[W-1:0];
        wr_acc = 1'b1;
        alu_upd = 1'b1;
        ph_d = shr[2*W-1:W];
        ph_we = 1'b1;
      end
      `AMS_OP_SHL_SUB, `AMS_OP_SHL_ADD:
      begin
        lo = shr[W-1:0];
        do_arith = 1'b1;
        do_sub = (CLASS3_SUBOP == `AMS_OP_SHL_SUB);
        wr_acc = 1'b1;
        alu_upd = 1'b1;
        ph_d = shr[2*W-1:W];
        ph_we = 1'b1;
      end
      `AMS_OP_MUL_HI:
      begin
        ph_d = prod_rnd_hi;
        ph_we = 1'b1;
      end
      `AMS_OP_SHL_HI:
      begin
        ph_d = shr[2*W-1:W];
        ph_we = 1'b1;
      end
      default:
      begin
        lo = {W{1'b0}};
      end
    endcase
  end

  always @*
  begin
    if (do_sub)
      sum = {1'b0, other} + {1'b0, ~lo} + {{W{1'b0}}, (STRING_MODE ? CARRY_FLAG : 1'b1)};
    else if (do_arith)
      sum = {1'b0, other} + {1'b0, lo} + {{W{1'b0}}, (STRING_MODE & CARRY_FLAG)};
    else
      sum = {1'b0, lo};
    res = sum[W-1:0];
    if (do_sub)
      ovf = (other[W-1] != lo[W-1]) && (res[W-1] != other[W-1]);
    else if (do_arith)
      ovf = (other[W-1] == lo[W-1]) && (res[W-1] != other[W-1]);
    else
      ovf = 1'b0;
    z_new = (res == {W{1'b0}}) & (~(STRING_MODE & do_arith) | ZERO_FLAG);
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ACC_WDATA <= `AMS_RST_WORD;
      ACC_WE <= 1'b0;
      ACC_WSEL <= 1'b0;
      SHIFT_VALUE_REG <= `AMS_RST_SV;
      PRODUCT_HIGH_REG <= `AMS_RST_WORD;
      MULTIPLIER_OPERAND_REG <= `AMS_RST_WORD;
      UNSIGNED_MULTIPLY_FLAG <= 1'b0;
      ZERO_FLAG <= 1'b0;
      CARRY_FLAG <= 1'b0;
      SIGN_FLAG <= 1'b0;
      OVF_FLAG <= 1'b0;
    end
    else
    begin
      ACC_WE <= EXEC & wr_acc;
      ACC_WSEL <= DST_SEL;
      ACC_WDATA <= res;
      if (EXEC)
      begin
        if (CLASS3_SUBOP == `AMS_OP_MOV_SV)
          SHIFT_VALUE_REG <= src[CW-1:0];
        if (CLASS3_SUBOP == `AMS_OP_MOV_MR || CLASS3_SUBOP == `AMS_OP_LOAD_MULT_UNSIGNED_MR)
        begin
          MULTIPLIER_OPERAND_REG <= src;
          UNSIGNED_MULTIPLY_FLAG <= (CLASS3_SUBOP == `AMS_OP_LOAD_MULT_UNSIGNED_MR);
        end
        if (ph_we)
          PRODUCT_HIGH_REG <= ph_d;
        if (do_xfer)
        begin
          ZERO_FLAG <= (src == {W{1'b0}});
          SIGN_FLAG <= src[W-1];
        end
        else if (alu_upd)
        begin
          ZERO_FLAG <= z_new;
          SIGN_FLAG <= res[W-1];
          CARRY_FLAG <= do_arith ? sum[W] : 1'b0;
          OVF_FLAG <= ovf;
        end
      end
    end
  end
endmodule // ams_top
